//--- core/tape_cmd_pkg.sv
// Constants shared by the tape command interpreter and its page builder.
// Assumes one clock domain; the opcode and page-code values are byte codes seen on the command channel.
package tape_cmd_pkg;
	localparam logic [7:0] OP_INQUIRY = 8'h12;
	localparam logic [7:0] OP_LOAD_UNLOAD = 8'h1B;
	localparam logic [7:0] PAGE_SUPPORTED = 8'h00;
	localparam logic [7:0] PAGE_SERIAL = 8'h80;
	localparam logic [2:0] QUALIFIER_CONNECTED = 3'h0;
	localparam logic [4:0] DEV_TYPE_SEQ = 5'h01;
	localparam logic [7:0] DEV_CODE_SEQ = 8'h01;
	localparam logic [7:0] DEV_CODE_BAD_LUN = 8'h7F;
	localparam logic [7:0] SUPPORTED_LEN = 8'h02;
	localparam logic [7:0] SERIAL_LEN = 8'h0A;
	localparam logic [7:0] PAD_BLANK = 8'h20;
	localparam logic [3:0] SENSE_NONE = 4'h0;
	localparam logic [3:0] SENSE_ILLEGAL_REQ = 4'h5;
	localparam logic [3:0] SENSE_MEDIUM_ERR = 4'h3;
	localparam logic [7:0] STATUS_GOOD = 8'h00;
	localparam logic [7:0] STATUS_CHECK = 8'h02;
	localparam int EVPD_BIT = 0;
	localparam int IMMED_BIT = 1;
	localparam int LOAD_BIT = 0;
	localparam int SERIAL_CHARS = 10;
	localparam int SUPPORTED_BYTES = 6;
	localparam int SERIAL_BYTES = 14;
	localparam int LUN_MSB = 7;
	localparam int LUN_LSB = 5;
	localparam int CDB_BYTES = 6;
endpackage

//--- core/vpd_page_rom.sv
// Combinational builder of the two vital-product-data pages.
// Assumes the caller holds page selection, unit number and serial steady.
`timescale 1ns/1ps
`default_nettype none
module vpd_page_rom #(
	parameter int SERIAL_CHARS = 10
) (
	input wire logic serial_page,
	input wire logic lun_nonzero,
	input wire logic [8*SERIAL_CHARS-1:0] serial_text,
	input wire logic [3:0] byte_index,
	output logic [7:0] page_byte
);
	always_comb begin
		page_byte = 8'h00;
		if (!serial_page) begin
			unique case (byte_index)
				4'h0: page_byte = {tape_cmd_pkg::QUALIFIER_CONNECTED,
					tape_cmd_pkg::DEV_TYPE_SEQ}; // see [RULE2]
				4'h1: page_byte = tape_cmd_pkg::PAGE_SUPPORTED; // see [RULE2]
				4'h3: page_byte = tape_cmd_pkg::SUPPORTED_LEN; // see [RULE3]
				4'h4: page_byte = tape_cmd_pkg::PAGE_SUPPORTED; // see [RULE3]
				4'h5: page_byte = tape_cmd_pkg::PAGE_SERIAL; // see [RULE3]
				default: page_byte = 8'h00;
			endcase
		end else begin
			if (byte_index == 4'h0) begin
				page_byte = lun_nonzero ? tape_cmd_pkg::DEV_CODE_BAD_LUN
					: tape_cmd_pkg::DEV_CODE_SEQ; // see [RULE5]
			end else if (byte_index == 4'h1) begin
				page_byte = tape_cmd_pkg::PAGE_SERIAL; // see [RULE4]
			end else if (byte_index == 4'h3) begin
				page_byte = tape_cmd_pkg::SERIAL_LEN; // see [RULE6]
			end else if (byte_index >= 4'h4 && byte_index <= 4'(SERIAL_CHARS + 3)) begin
				// Character 0 is the most significant byte of serial_text.
				page_byte = serial_text[8*SERIAL_CHARS-1-8*(byte_index-4'h4) -: 8]; // see [RULE6]
				if (page_byte == 8'h00) begin
					page_byte = tape_cmd_pkg::PAD_BLANK; // see [RULE6]
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- core/tape_cmd_ctrl.sv
// Command interpreter for inquiry pages and load/unload on a tape drive.
// Assumes a front end that delivers one six-byte command block per strobe,
// and a mechanism that reports each requested step with a done pulse.
//
// How it works
// [RULE1] Page 00h inquiry returns supported-pages list.
// [RULE2] Supported list: type 01h, page code 00h.
// [RULE3] Length 02h, then codes 00h and 80h.
// [RULE4] Page 80h inquiry returns serial page.
// [RULE5] Byte 0 is 01h, or 7Fh for nonzero unit.
// [RULE6] Length 0Ah, serial MSB first, blank padded.
// [RULE7] Opcode 1Bh, byte 4 bit 0 picks load.
// [RULE8] Load threads tape then seeks logical start.
// [RULE9] Unload: flush, rewind, unthread, eject in order.
// [RULE10] Discard data left by a failed write first; discard_buffer pulses in the same cycle as the first step request or status.
// [RULE11] Two partitions: second, unless select or default.
// [RULE12] Immediate flag returns status at start; unload without cartridge still reports only after the eject.
// [RULE13] Pending data: disconnect, flush, reconnect, good, operate.
// [RULE14] Flush failure: check condition, skip the operation.
// [RULE15] End-of-tape and retension bits are ignored.
// [RULE16] Unload without cartridge opens door, even prevented.
// [RULE17] Load without cartridge: check, illegal request.
// [RULE18] Prevented removal: unload everything except eject.
// [RULE19] Loaded at start, empty buffer: no motion.
// [RULE20] Two-partition unload same as single partition.
// [RULE21] Unknown page code: check, illegal request.
`timescale 1ns/1ps
`default_nettype none
module tape_cmd_ctrl #(
	parameter int SERIAL_CHARS = 10
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic cmd_valid,
	input wire logic [8*6-1:0] cmd_bytes,
	input wire logic disconnect_ok,
	input wire logic [8*SERIAL_CHARS-1:0] serial_text,
	input wire logic cartridge_in,
	input wire logic tape_threaded,
	input wire logic at_logical_tape_start,
	input wire logic buffer_pending,
	input wire logic write_failed_data,
	input wire logic removal_prevented,
	input wire logic two_partitions,
	input wire logic load_partition_select,
	input wire logic nv_first_partition,
	input wire logic mech_done,
	input wire logic mech_fail,
	output logic data_valid,
	output logic [7:0] data_byte,
	output logic data_last,
	output logic status_valid,
	output logic [7:0] status_code,
	output logic [3:0] sense_key,
	output logic bus_disconnect,
	output logic discard_buffer,
	output logic flush_req,
	output logic thread_req,
	output logic seek_logical_start,
	output logic seek_first_partition,
	output logic rewind_physical_start,
	output logic unthread_req,
	output logic eject_req,
	output logic busy
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_PAGE = 9'h002,
		ST_FLUSH = 9'h004,
		ST_THREAD = 9'h008,
		ST_SEEK = 9'h010,
		ST_REWIND = 9'h020,
		ST_UNTHREAD = 9'h040,
		ST_EJECT = 9'h080,
		ST_FINISH = 9'h100
	} phase_t;

	typedef struct packed {
		phase_t phase;
		logic is_load;
		logic immed;
		logic serial_page;
		logic lun_nonzero;
		logic [3:0] idx;
		logic status_sent;
		logic data_valid;
		logic [7:0] data_byte;
		logic data_last;
		logic status_valid;
		logic [7:0] status_code;
		logic [3:0] sense_key;
		logic bus_disconnect;
		logic discard_buffer;
		logic flush_req;
		logic thread_req;
		logic seek_logical_start;
		logic seek_first_partition;
		logic rewind_physical_start;
		logic unthread_req;
		logic eject_req;
		logic busy;
	} ctrl_t;

	localparam ctrl_t CTRL_RESET = '{phase: ST_IDLE, status_code: tape_cmd_pkg::STATUS_GOOD,
		sense_key: tape_cmd_pkg::SENSE_NONE, default: '0};

	ctrl_t state_reg;
	ctrl_t state_next;
	logic [7:0] page_byte;
	logic [7:0] op;
	logic [7:0] b1;
	logic [7:0] b2;
	logic [7:0] b4;

	assign op = cmd_bytes[47:40];
	assign b1 = cmd_bytes[39:32];
	assign b2 = cmd_bytes[31:24];
	assign b4 = cmd_bytes[15:8];

	vpd_page_rom #(
		.SERIAL_CHARS(SERIAL_CHARS)
	) u_rom (
		.serial_page(state_reg.serial_page),
		.lun_nonzero(state_reg.lun_nonzero),
		.serial_text(serial_text),
		.byte_index(state_reg.idx),
		.page_byte(page_byte)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// Status is a pulse; with the immediate flag it may be sent while the
	// mechanism still works, so status_sent stops a second report.
	always_comb begin
		state_next = state_reg;
		state_next.data_valid = 1'b0;
		state_next.data_last = 1'b0;
		state_next.status_valid = 1'b0;
		state_next.discard_buffer = 1'b0;
		state_next.flush_req = 1'b0;
		state_next.thread_req = 1'b0;
		state_next.seek_logical_start = 1'b0;
		state_next.rewind_physical_start = 1'b0;
		state_next.unthread_req = 1'b0;
		state_next.eject_req = 1'b0;
		unique case (state_reg.phase)
			ST_IDLE: begin
				state_next.bus_disconnect = 1'b0;
				state_next.status_sent = 1'b0;
				if (cmd_valid) begin
					state_next.sense_key = tape_cmd_pkg::SENSE_NONE;
					state_next.lun_nonzero = |b1[tape_cmd_pkg::LUN_MSB:tape_cmd_pkg::LUN_LSB];
					state_next.idx = 4'h0;
					if (op == tape_cmd_pkg::OP_INQUIRY && b1[tape_cmd_pkg::EVPD_BIT]) begin
						if (b2 == tape_cmd_pkg::PAGE_SUPPORTED || b2 == tape_cmd_pkg::PAGE_SERIAL) begin
							state_next.serial_page = (b2 == tape_cmd_pkg::PAGE_SERIAL); // see [RULE1] see [RULE4]
							state_next.phase = ST_PAGE;
						end else begin
							state_next.status_valid = 1'b1; // see [RULE21]
							state_next.status_code = tape_cmd_pkg::STATUS_CHECK;
							state_next.sense_key = tape_cmd_pkg::SENSE_ILLEGAL_REQ;
						end
					end else if (op == tape_cmd_pkg::OP_LOAD_UNLOAD) begin
						// End-of-tape and retension bits of byte 4 are never read.
						state_next.is_load = b4[tape_cmd_pkg::LOAD_BIT]; // see [RULE7] see [RULE15]
						state_next.immed = b1[tape_cmd_pkg::IMMED_BIT];
						state_next.discard_buffer = write_failed_data; // see [RULE10]
						state_next.seek_first_partition = two_partitions
							? (load_partition_select | nv_first_partition) : 1'b1; // see [RULE11]
						if (!cartridge_in) begin
							if (b4[tape_cmd_pkg::LOAD_BIT]) begin
								state_next.status_valid = 1'b1; // see [RULE17]
								state_next.status_code = tape_cmd_pkg::STATUS_CHECK;
								state_next.sense_key = tape_cmd_pkg::SENSE_ILLEGAL_REQ;
							end else begin
								state_next.eject_req = 1'b1; // see [RULE16]
								state_next.phase = ST_EJECT;
							end
						end else if (buffer_pending && !write_failed_data) begin
							state_next.bus_disconnect = disconnect_ok; // see [RULE13]
							state_next.flush_req = 1'b1;
							state_next.phase = ST_FLUSH;
						end else if (b4[tape_cmd_pkg::LOAD_BIT] && tape_threaded
							&& at_logical_tape_start) begin
							state_next.status_valid = 1'b1; // see [RULE19]
							state_next.status_code = tape_cmd_pkg::STATUS_GOOD;
						end else begin
							state_next.status_valid = b1[tape_cmd_pkg::IMMED_BIT]; // see [RULE12]
							state_next.status_sent = b1[tape_cmd_pkg::IMMED_BIT];
							state_next.status_code = tape_cmd_pkg::STATUS_GOOD;
							if (b4[tape_cmd_pkg::LOAD_BIT]) begin
								state_next.thread_req = 1'b1; // see [RULE8]
								state_next.phase = ST_THREAD;
							end else begin
								// Same path whatever partition is current.
								state_next.rewind_physical_start = 1'b1; // see [RULE9] see [RULE20]
								state_next.phase = ST_REWIND;
							end
						end
					end
				end
			end
			ST_PAGE: begin
				state_next.data_valid = 1'b1;
				state_next.data_byte = page_byte;
				state_next.idx = state_reg.idx + 4'h1;
				if ((!state_reg.serial_page && state_reg.idx == 4'(tape_cmd_pkg::SUPPORTED_BYTES - 1))
					|| (state_reg.serial_page && state_reg.idx == 4'(tape_cmd_pkg::SERIAL_BYTES - 1))) begin
					state_next.data_last = 1'b1;
					state_next.status_valid = 1'b1;
					state_next.status_code = tape_cmd_pkg::STATUS_GOOD;
					state_next.phase = ST_IDLE;
				end
			end
			ST_FLUSH: begin
				if (mech_fail) begin
					state_next.bus_disconnect = 1'b0; // see [RULE14]
					state_next.status_valid = 1'b1;
					state_next.status_code = tape_cmd_pkg::STATUS_CHECK;
					state_next.sense_key = tape_cmd_pkg::SENSE_MEDIUM_ERR;
					state_next.phase = ST_IDLE;
				end else if (mech_done) begin
					state_next.bus_disconnect = 1'b0;
					state_next.status_valid = state_reg.immed; // see [RULE13]
					state_next.status_sent = state_reg.immed;
					state_next.status_code = tape_cmd_pkg::STATUS_GOOD;
					if (state_reg.is_load) begin
						if (tape_threaded) begin
							state_next.seek_logical_start = 1'b1; // see [RULE19]
							state_next.phase = ST_SEEK;
						end else begin
							state_next.thread_req = 1'b1;
							state_next.phase = ST_THREAD;
						end
					end else begin
						state_next.rewind_physical_start = 1'b1; // see [RULE9]
						state_next.phase = ST_REWIND;
					end
				end
			end
			ST_THREAD: begin
				if (mech_done) begin
					state_next.seek_logical_start = 1'b1; // see [RULE8]
					state_next.phase = ST_SEEK;
				end
			end
			ST_SEEK: begin
				if (mech_done) begin
					state_next.phase = ST_FINISH;
				end
			end
			ST_REWIND: begin
				if (mech_done) begin
					state_next.unthread_req = 1'b1; // see [RULE9]
					state_next.phase = ST_UNTHREAD;
				end
			end
			ST_UNTHREAD: begin
				if (mech_done) begin
					if (removal_prevented) begin
						state_next.phase = ST_FINISH; // see [RULE18]
					end else begin
						state_next.eject_req = 1'b1; // see [RULE9]
						state_next.phase = ST_EJECT;
					end
				end
			end
			ST_EJECT: begin
				if (mech_done) begin
					state_next.phase = ST_FINISH;
				end
			end
			ST_FINISH: begin
				state_next.status_valid = !state_reg.status_sent; // see [RULE12]
				state_next.status_code = tape_cmd_pkg::STATUS_GOOD;
				state_next.phase = ST_IDLE;
			end
			default: begin
				state_next = CTRL_RESET;
			end
		endcase
		// Busy is registered with the phase so that the port comes from a flip-flop.
		state_next.busy = (state_next.phase != ST_IDLE);
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= CTRL_RESET;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	always_comb begin
		data_valid = state_reg.data_valid;
		data_byte = state_reg.data_byte;
		data_last = state_reg.data_last;
		status_valid = state_reg.status_valid;
		status_code = state_reg.status_code;
		sense_key = state_reg.sense_key;
		bus_disconnect = state_reg.bus_disconnect;
		discard_buffer = state_reg.discard_buffer;
		flush_req = state_reg.flush_req;
		thread_req = state_reg.thread_req;
		seek_logical_start = state_reg.seek_logical_start;
		seek_first_partition = state_reg.seek_first_partition;
		rewind_physical_start = state_reg.rewind_physical_start;
		unthread_req = state_reg.unthread_req;
		eject_req = state_reg.eject_req;
		busy = state_reg.busy;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_page0_first;
		@(posedge ref_clk) disable iff (!nrst)
		(clk_en && state_reg.phase == ST_PAGE && !state_reg.serial_page && state_reg.idx == 4'h0)
			|=> data_byte == 8'h01;
	endproperty
	a_page0_first: assert property (p_page0_first) else $error("bad type byte"); // see [RULE2]

	property p_page0_second_code;
		@(posedge ref_clk) disable iff (!nrst)
		(clk_en && state_reg.phase == ST_PAGE && !state_reg.serial_page && state_reg.idx == 4'h5)
			|=> data_byte == 8'h80 && data_last && status_valid;
	endproperty
	a_page0_second_code: assert property (p_page0_second_code) else $error("bad list end"); // see [RULE3]

	property p_serial_type;
		@(posedge ref_clk) disable iff (!nrst)
		(clk_en && state_reg.phase == ST_PAGE && state_reg.serial_page && state_reg.idx == 4'h0)
			|=> data_byte == (state_reg.lun_nonzero ? 8'h7F : 8'h01);
	endproperty
	a_serial_type: assert property (p_serial_type) else $error("bad unit byte"); // see [RULE5]

	property p_serial_len;
		@(posedge ref_clk) disable iff (!nrst)
		(clk_en && state_reg.phase == ST_PAGE && state_reg.serial_page && state_reg.idx == 4'h3)
			|=> data_byte == 8'h0A;
	endproperty
	a_serial_len: assert property (p_serial_len) else $error("bad serial length"); // see [RULE6]

	property p_no_cart_load;
		@(posedge ref_clk) disable iff (!nrst)
		(clk_en && state_reg.phase == ST_IDLE && cmd_valid && op == 8'h1B && b4[0] && !cartridge_in)
			|=> status_valid && status_code == 8'h02 && sense_key == 4'h5;
	endproperty
	a_no_cart_load: assert property (p_no_cart_load) else $error("load without cartridge"); // see [RULE17]

	property p_no_cart_unload;
		@(posedge ref_clk) disable iff (!nrst)
		(clk_en && state_reg.phase == ST_IDLE && cmd_valid && op == 8'h1B && !b4[0] && !cartridge_in)
			|=> eject_req;
	endproperty
	a_no_cart_unload: assert property (p_no_cart_unload) else $error("door not opened"); // see [RULE16]

	property p_flush_fail;
		@(posedge ref_clk) disable iff (!nrst)
		(clk_en && state_reg.phase == ST_FLUSH && mech_fail)
			|=> status_code == 8'h02 && !thread_req && !rewind_physical_start && busy == 1'b0;
	endproperty
	a_flush_fail: assert property (p_flush_fail) else $error("flush failure ignored"); // see [RULE14]

	property p_prevent_no_eject;
		@(posedge ref_clk) disable iff (!nrst)
		(clk_en && state_reg.phase == ST_UNTHREAD && mech_done && removal_prevented)
			|=> !eject_req;
	endproperty
	a_prevent_no_eject: assert property (p_prevent_no_eject) else $error("ejected while prevented"); // see [RULE18]

	property p_rewind_then_unthread;
		@(posedge ref_clk) disable iff (!nrst)
		(clk_en && state_reg.phase == ST_REWIND && mech_done) |=> unthread_req;
	endproperty
	a_rewind_then_unthread: assert property (p_rewind_then_unthread) else $error("order broken"); // see [RULE9]
endmodule
`default_nettype wire

//--- dv/mech_model.sv
// Stand-in for the tape mechanism: answers each step request with a done pulse, or a fail pulse for a failing flush.
// Assumes one step at a time, each requested by a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module mech_model (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic step_req,
	input wire logic flush_step,
	input wire logic fail_flush,
	input wire logic slow,
	output logic mech_done,
	output logic mech_fail
);
	logic [3:0] cnt_reg;
	logic fail_reg;
	// A slow answer keeps the controller waiting, so that no step may rely on a fixed delay.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_reg <= 4'h0;
			fail_reg <= 1'b0;
			mech_done <= 1'b0;
			mech_fail <= 1'b0;
		end else begin
			mech_done <= (cnt_reg == 4'h1) && !fail_reg;
			mech_fail <= (cnt_reg == 4'h1) && fail_reg;
			if (step_req) begin
				cnt_reg <= slow ? 4'h6 : 4'h2;
				fail_reg <= flush_step && fail_flush;
			end else if (cnt_reg != 4'h0) begin
				cnt_reg <= cnt_reg - 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the tape command interpreter.
// Assumes the mechanism model answers steps; levels are set before each command.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic ref_clk, nrst, cmd_valid, disconnect_ok, mech_done, mech_fail, fail_flush, slow;
	logic clk_en;
	logic [47:0] cmd_bytes;
	logic [79:0] serial_text;
	logic cartridge_in, tape_threaded, at_logical_tape_start, buffer_pending, write_failed_data;
	logic removal_prevented, two_partitions, load_partition_select, nv_first_partition;
	logic data_valid, data_last, status_valid, bus_disconnect, discard_buffer, flush_req;
	logic thread_req, seek_logical_start, seek_first_partition, rewind_physical_start;
	logic unthread_req, eject_req, busy;
	logic [7:0] data_byte, status_code;
	logic [3:0] sense_key, sense_seen;
	logic got_status, sfp_seen, disc_seen;
	string log;
	logic [7:0] page[$];
	logic [7:0] exp_pg[$];
	int last_at, mismatches, checks_done;

	tape_cmd_ctrl #(.SERIAL_CHARS(10)) dut_u (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
		.cmd_valid(cmd_valid), .cmd_bytes(cmd_bytes), .disconnect_ok(disconnect_ok),
		.serial_text(serial_text), .cartridge_in(cartridge_in), .tape_threaded(tape_threaded),
		.at_logical_tape_start(at_logical_tape_start), .buffer_pending(buffer_pending),
		.write_failed_data(write_failed_data), .removal_prevented(removal_prevented),
		.two_partitions(two_partitions), .load_partition_select(load_partition_select),
		.nv_first_partition(nv_first_partition), .mech_done(mech_done), .mech_fail(mech_fail),
		.data_valid(data_valid), .data_byte(data_byte), .data_last(data_last),
		.status_valid(status_valid), .status_code(status_code), .sense_key(sense_key),
		.bus_disconnect(bus_disconnect), .discard_buffer(discard_buffer), .flush_req(flush_req),
		.thread_req(thread_req), .seek_logical_start(seek_logical_start),
		.seek_first_partition(seek_first_partition), .rewind_physical_start(rewind_physical_start),
		.unthread_req(unthread_req), .eject_req(eject_req), .busy(busy));

	mech_model mech_u (.ref_clk(ref_clk), .nrst(nrst), .flush_step(flush_req),
		.step_req(flush_req | thread_req | seek_logical_start | rewind_physical_start
			| unthread_req | eject_req),
		.fail_flush(fail_flush), .slow(slow), .mech_done(mech_done), .mech_fail(mech_fail));

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// ----------------------------------------------------------------
	// Monitor: steps and status land in one string, so order is checked whole.
	// ----------------------------------------------------------------
	always @(posedge ref_clk) begin
		// Status goes first, so an immediate report in the cycle of a step reads before it.
		if (status_valid === 1'b1) begin
			log = {log, (status_code === tape_cmd_pkg::STATUS_GOOD) ? "G" : "C"};
			sense_seen = sense_key;
			got_status = 1'b1;
		end
		if (discard_buffer === 1'b1) log = {log, "D"};
		if (flush_req === 1'b1) log = {log, "F"};
		if (thread_req === 1'b1) log = {log, "T"};
		if (seek_logical_start === 1'b1) log = {log, "S"};
		if (seek_logical_start === 1'b1) sfp_seen = seek_first_partition;
		if (rewind_physical_start === 1'b1) log = {log, "R"};
		if (unthread_req === 1'b1) log = {log, "U"};
		if (eject_req === 1'b1) log = {log, "E"};
		if (bus_disconnect === 1'b1) disc_seen = 1'b1;
		if (data_valid === 1'b1) begin
			page.push_back(data_byte);
			if (data_last === 1'b1) last_at = page.size();
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	function automatic logic [47:0] cdb(input logic [7:0] op, b1, b2, b4);
		return {op, b1, b2, 8'h00, b4, 8'h00};
	endfunction

	task automatic env(input logic [8:0] v);
		@(negedge ref_clk);
		{cartridge_in, tape_threaded, at_logical_tape_start, buffer_pending, write_failed_data,
			removal_prevented, two_partitions, load_partition_select, nv_first_partition} = v;
	endtask

	task automatic do_cmd(input string nm, input logic [47:0] c, input string exp_log,
			input logic [3:0] exp_sense);
		int n;
		@(negedge ref_clk);
		log = "";
		page.delete();
		last_at = 0;
		got_status = 1'b0;
		disc_seen = 1'b0;
		cmd_valid = 1'b1;
		cmd_bytes = c;
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		n = 0;
		while (!(got_status && busy === 1'b0) && n < 300) begin
			@(negedge ref_clk);
			n++;
		end
		chk("command finished", 8'h01, {7'h0, n < 300});
		repeat (3) @(negedge ref_clk);
		checks_done++;
		if (log != exp_log) begin
			mismatches++;
			$display("wrong value %s sequence expected %s seen %s", nm, exp_log, log);
		end
		if (exp_sense !== 4'hF) chk("sense_key", {4'h0, exp_sense}, {4'h0, sense_seen});
		$display("test %s done", nm);
	endtask

	task automatic chk_page;
		chk("page length", 8'(exp_pg.size()), 8'(page.size()));
		chk("last byte position", 8'(exp_pg.size()), 8'(last_at));
		foreach (exp_pg[i]) chk("page byte", exp_pg[i], (i < page.size()) ? page[i] : 8'hXX);
	endtask

	task finish_test;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		#200000;
		mismatches++;
		finish_test;
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		nrst = 1'b0;
		{cmd_valid, fail_flush, slow, disconnect_ok} = 4'h0;
		clk_en = 1'b1;
		cmd_bytes = 48'h0;
		serial_text = {"AB12C", 40'h0};
		{cartridge_in, tape_threaded, at_logical_tape_start, buffer_pending, write_failed_data,
			removal_prevented, two_partitions, load_partition_select, nv_first_partition} = 9'h0;
		mismatches = 0;
		checks_done = 0;
		repeat (10) @(negedge ref_clk);
		nrst = 1'b1;
		do_cmd("supported pages", cdb(8'h12, 8'h01, 8'h00, 8'h00), "G", 4'hF);
		exp_pg = '{8'h01, 8'h00, 8'h00, 8'h02, 8'h00, 8'h80};
		chk_page;
		do_cmd("serial page", cdb(8'h12, 8'h01, 8'h80, 8'h00), "G", 4'hF);
		exp_pg = '{8'h01, 8'h80, 8'h00, 8'h0A, 8'h41, 8'h42, 8'h31, 8'h32, 8'h43,
			8'h20, 8'h20, 8'h20, 8'h20, 8'h20};
		chk_page;
		do_cmd("serial bad unit", cdb(8'h12, 8'h21, 8'h80, 8'h00), "G", 4'hF);
		chk("unit code", 8'h7F, page.size() > 0 ? page[0] : 8'hXX);
		do_cmd("unknown page", cdb(8'h12, 8'h01, 8'h83, 8'h00), "C", 4'h5);
		// With the enable low a command must be lost and no state may move.
		@(negedge ref_clk);
		clk_en = 1'b0;
		log = "";
		cmd_valid = 1'b1;
		cmd_bytes = cdb(8'h12, 8'h01, 8'h83, 8'h00);
		repeat (4) @(negedge ref_clk);
		cmd_valid = 1'b0;
		clk_en = 1'b1;
		repeat (4) @(negedge ref_clk);
		checks_done++;
		if (log != "" || busy !== 1'b0) begin
			mismatches++;
			$display("wrong value frozen sequence expected none seen %s", log);
		end
		$display("test frozen done");
		env(9'b110000100);
		do_cmd("unload", cdb(8'h1B, 8'h00, 8'h00, 8'h06), "RUEG", 4'hF);
		slow = 1'b1;
		do_cmd("unload immed", cdb(8'h1B, 8'h02, 8'h00, 8'h00), "GRUE", 4'hF);
		env(9'b110001000);
		do_cmd("unload prevented", cdb(8'h1B, 8'h00, 8'h00, 8'h00), "RUG", 4'hF);
		env(9'b000001000);
		do_cmd("unload empty", cdb(8'h1B, 8'h00, 8'h00, 8'h00), "EG", 4'hF);
		do_cmd("load empty", cdb(8'h1B, 8'h00, 8'h00, 8'h01), "C", 4'h5);
		env(9'b111000000);
		do_cmd("load at start", cdb(8'h1B, 8'h00, 8'h00, 8'h07), "G", 4'hF);
		env(9'b100000100);
		do_cmd("load second part", cdb(8'h1B, 8'h00, 8'h00, 8'h01), "TSG", 4'hF);
		chk("partition select", 8'h00, {7'h0, sfp_seen});
		env(9'b100000110);
		do_cmd("load select first", cdb(8'h1B, 8'h00, 8'h00, 8'h01), "TSG", 4'hF);
		chk("partition select", 8'h01, {7'h0, sfp_seen});
		env(9'b100000101);
		do_cmd("load default first", cdb(8'h1B, 8'h00, 8'h00, 8'h01), "TSG", 4'hF);
		chk("partition select", 8'h01, {7'h0, sfp_seen});
		disconnect_ok = 1'b1;
		env(9'b110100000);
		do_cmd("load pending immed", cdb(8'h1B, 8'h02, 8'h00, 8'h01), "FGS", 4'hF);
		chk("disconnect", 8'h01, {7'h0, disc_seen});
		chk("disconnect released", 8'h00, {7'h0, bus_disconnect});
		do_cmd("unload pending", cdb(8'h1B, 8'h00, 8'h00, 8'h00), "FRUEG", 4'hF);
		fail_flush = 1'b1;
		do_cmd("flush fails", cdb(8'h1B, 8'h02, 8'h00, 8'h00), "FC", 4'h3);
		fail_flush = 1'b0;
		env(9'b110110000);
		do_cmd("failed write", cdb(8'h1B, 8'h00, 8'h00, 8'h00), "DRUEG", 4'hF);
		finish_test;
	end
endmodule
`default_nettype wire
